/* logic/sipl_defs.vh */
// constants for the sensor interrupt pin logic
`ifndef SIPL_DEFS_VH
`define SIPL_DEFS_VH

// ****************************************
// register indices on the internal register port
// ****************************************
`define SIPL_ADDR_IRQ_OUTPUT_CONFIG 8'h00
`define SIPL_ADDR_IRQ_SOURCE_EN 8'h01
`define SIPL_ADDR_IRQ_STATUS 8'h02
`define SIPL_ADDR_OOR_REF_LO 8'h03
`define SIPL_ADDR_OOR_REF_MID 8'h04
`define SIPL_ADDR_OOR_RANGE 8'h05
`define SIPL_ADDR_OOR_CFG 8'h06

// ****************************************
// field positions
// ****************************************
// irq_output_config
`define SIPL_CFG_MODE 0
`define SIPL_CFG_POL 1
`define SIPL_CFG_DRIVE 2
`define SIPL_CFG_EN 3
// source enable and status share these positions
`define SIPL_SRC_DRDY 0
`define SIPL_SRC_THS 1
`define SIPL_SRC_FULL 2
`define SIPL_SRC_OOR 3
`define SIPL_STS_POR 4
// oor cfg
`define SIPL_OOR_REF16 0
`define SIPL_OOR_CNT_LO 1
`define SIPL_OOR_CNT_HI 2

// ****************************************
// reset values
// ****************************************
`define SIPL_RST_CONFIG 8'h00
`define SIPL_RST_SOURCE 8'h00
`define SIPL_RST_OOR 8'h00

// ****************************************
// timing
// ****************************************
`define SIPL_CLK_NS 50
`define SIPL_PULSE_NS 500
`define SIPL_GAP_NS 1000
`define SIPL_PULSE_CYC ((`SIPL_PULSE_NS + `SIPL_CLK_NS - 1) / `SIPL_CLK_NS)
`define SIPL_GAP_CYC ((`SIPL_GAP_NS + `SIPL_CLK_NS - 1) / `SIPL_CLK_NS)

`endif

/* logic/sipl_oor_check.v */
// out-of-range window check with consecutive sample counter
`timescale 1ns/100ps
`include "sipl_defs.vh"

module sipl_oor_check
(
   // clock and reset
   input wire clock,
   input wire rst,
   // measurement
   input wire sample_valid,
   input wire [16:0] pressure,
   input wire flush,
   // configuration
   input wire [16:0] ref_value,
   input wire [7:0] half_width,
   input wire [1:0] cnt_lim,
   // result
   output reg oor_evt_ff
);

   reg [2:0] run_cnt_ff;
   reg [2:0] nxt_run_cnt;
   reg nxt_oor_evt;
   wire [17:0] upper;
   wire [17:0] p_plus;
   wire outside;

   // compare in 18 bits so the window edges never wrap
   assign upper = {1'b0, ref_value} + {10'h000, half_width};
   assign p_plus = {1'b0, pressure} + {10'h000, half_width};
   assign outside = ({1'b0, pressure} > upper) || (p_plus < {1'b0, ref_value});

   // count consecutive outside samples, event each sample once limit met
   always @*
   begin
      nxt_run_cnt = run_cnt_ff;
      nxt_oor_evt = 1'b0;
      if (flush)
      begin
         nxt_run_cnt = 3'h0;
      end
      else if (sample_valid)
      begin
         if (!outside)
         begin
            nxt_run_cnt = 3'h0;
         end
         else
         begin
            if (run_cnt_ff <= {1'b0, cnt_lim})
            begin
               nxt_run_cnt = run_cnt_ff + 3'h1;
            end
            // limit is cnt_lim+1 samples; keeps firing while still outside
            nxt_oor_evt = (run_cnt_ff >= {1'b0, cnt_lim});
         end
      end
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         run_cnt_ff <= 3'h0;
         oor_evt_ff <= 1'b0;
      end
      else
      begin
         run_cnt_ff <= nxt_run_cnt;
         oor_evt_ff <= nxt_oor_evt;
      end
   end

endmodule

/* logic/sipl_pin_drive.v */
// interrupt pin output stage: polarity and drive type
`timescale 1ns/100ps

module sipl_pin_drive
(
   // clock and reset
   input wire clock,
   input wire rst,
   // control
   input wire asserted,
   input wire active_high,
   input wire irq_drive_type,
   input wire pin_en,
   // pin
   output reg irq_pin_o_ff,
   output reg irq_pin_oe_ff
);

   wire level;

   assign level = active_high ? asserted : ~asserted;

   // open drain only ever pulls low; disabled pin floats
   always @(posedge clock)
   begin
      if (rst)
      begin
         irq_pin_o_ff <= 1'b0;
         irq_pin_oe_ff <= 1'b0;
      end
      else if (!pin_en)
      begin
         irq_pin_o_ff <= 1'b0;
         irq_pin_oe_ff <= 1'b0;
      end
      else if (irq_drive_type)
      begin
         irq_pin_o_ff <= 1'b0;
         irq_pin_oe_ff <= ~level;
      end
      else
      begin
         irq_pin_o_ff <= level;
         irq_pin_oe_ff <= 1'b1;
      end
   end

endmodule

/* logic/sipl_top.v */
// sensor interrupt pin logic: status, source combining and pin timing
// How it works
// - config bit picks pulsed or latched
// - config bit picks active high or low
// - config bit picks open-drain or push-pull
// - pin enable ORs all enabled sources
// - pulsed: one pulse per rising condition
// - pulse lasts pulse time, gap enforced
// - latched: asserted while any condition true
// - latched: minimum gap between assertions
// - fifo contributions drop when condition ends
// - data-ready drops after status read
// - out-of-range drops after status read
// - new data during release keeps pin asserted
// - fifo disable or flush drops fifo interrupt
// - flush also drops out-of-range interrupt
// - threshold rewrite deasserts, reasserts after gap
// - gap kept for drdy and oor combined
// - status bits never self-clear
// - fifo status clears when gone and read
// - drdy and oor status clear on read
// - interrupts continue during fifo readout
// - fifo conditions raised at measurement end
// - oor window compare over sample count
// - data ready on new results
// - power-up status bit, never on pin
`timescale 1ns/100ps
`include "sipl_defs.vh"

module sipl_top
(
   // clock and reset
   input wire clock,
   input wire rst,
   // register port from the host interface
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_ff,
   // measurement core
   input wire meas_done,
   input wire [16:0] pressure,
   // fifo
   input wire fifo_enabled,
   input wire fifo_flush,
   input wire fifo_full_cond,
   input wire fifo_ths_cond,
   input wire fifo_ths_rewrite,
   // interrupt pin
   output wire irq_pin_o,
   output wire irq_pin_oe
);

   // ****************************************
   // state machine codes
   // ****************************************
   localparam ST_IDLE = 2'b00;
   localparam ST_ASSERT = 2'b01;
   localparam ST_GAP = 2'b10;
   localparam [31:0] PULSE_W = `SIPL_PULSE_CYC;
   localparam [31:0] GAP_W = `SIPL_GAP_CYC;
   localparam [7:0] PULSE_CYC = PULSE_W[7:0];
   localparam [7:0] GAP_CYC = GAP_W[7:0];

   // ****************************************
   // registers
   // ****************************************
   reg [7:0] irq_output_config_ff;
   reg [7:0] irq_source_en_ff;
   reg [7:0] oor_ref_lo_ff;
   reg [7:0] oor_ref_mid_ff;
   reg [7:0] oor_range_ff;
   reg [7:0] oor_cfg_ff;
   reg [4:0] status_ff;
   reg [4:0] nxt_status;
   reg full_act_ff;
   reg ths_act_ff;
   reg nxt_full_act;
   reg nxt_ths_act;
   reg full_prev_ff;
   reg ths_prev_ff;
   reg ths_reeval_ff;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [7:0] cnt_ff;
   reg [7:0] nxt_cnt;
   reg pending_ff;
   reg nxt_pending;
   reg asserted_ff;
   reg nxt_asserted;
   reg [7:0] nxt_rdata;

   wire status_rd;
   wire fifo_kill;
   wire oor_evt;
   wire mode_latched;
   wire pin_en;
   wire [3:0] en;
   wire [3:0] pulse_src;
   wire [3:0] latch_src;
   wire pulse_trig;
   wire latch_level;
   wire drop_now;

   // ****************************************
   // register writes
   // ****************************************
   // mode-change order is the host's duty; not policed here
   always @(posedge clock)
   begin
      if (rst)
      begin
         irq_output_config_ff <= `SIPL_RST_CONFIG;
         irq_source_en_ff <= `SIPL_RST_SOURCE;
         oor_ref_lo_ff <= `SIPL_RST_OOR;
         oor_ref_mid_ff <= `SIPL_RST_OOR;
         oor_range_ff <= `SIPL_RST_OOR;
         oor_cfg_ff <= `SIPL_RST_OOR;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `SIPL_ADDR_IRQ_OUTPUT_CONFIG)
         begin
            irq_output_config_ff <= {4'h0, reg_wdata[3:0]};
         end
         else if (reg_addr == `SIPL_ADDR_IRQ_SOURCE_EN)
         begin
            irq_source_en_ff <= {4'h0, reg_wdata[3:0]};
         end
         else if (reg_addr == `SIPL_ADDR_OOR_REF_LO)
         begin
            oor_ref_lo_ff <= reg_wdata;
         end
         else if (reg_addr == `SIPL_ADDR_OOR_REF_MID)
         begin
            oor_ref_mid_ff <= reg_wdata;
         end
         else if (reg_addr == `SIPL_ADDR_OOR_RANGE)
         begin
            oor_range_ff <= reg_wdata;
         end
         else if (reg_addr == `SIPL_ADDR_OOR_CFG)
         begin
            oor_cfg_ff <= {5'h00, reg_wdata[2:0]};
         end
      end
   end

   // ****************************************
   // decoded controls
   // ****************************************
   assign mode_latched = irq_output_config_ff[`SIPL_CFG_MODE];
   assign pin_en = irq_output_config_ff[`SIPL_CFG_EN];
   assign en = irq_source_en_ff[3:0];
   assign status_rd = reg_rd && (reg_addr == `SIPL_ADDR_IRQ_STATUS);
   // a disabled fifo behaves like a flush for its own interrupts
   assign fifo_kill = fifo_flush || !fifo_enabled;

   // ****************************************
   // out-of-range detector
   // ****************************************
   sipl_oor_check u_oor
   (
      .clock(clock),
      .rst(rst),
      .sample_valid(meas_done),
      .pressure(pressure),
      .flush(fifo_flush),
      .ref_value({oor_cfg_ff[`SIPL_OOR_REF16], oor_ref_mid_ff, oor_ref_lo_ff}),
      .half_width(oor_range_ff),
      .cnt_lim(oor_cfg_ff[`SIPL_OOR_CNT_HI:`SIPL_OOR_CNT_LO]),
      .oor_evt_ff(oor_evt)
   );

   // ****************************************
   // fifo condition tracking
   // ****************************************
   // conditions are sampled at measurement end (threshold also right after a rewrite), then follow the level
   always @*
   begin
      nxt_full_act = full_act_ff;
      nxt_ths_act = ths_act_ff;
      if (!fifo_full_cond)
      begin
         nxt_full_act = 1'b0;
      end
      else if (meas_done)
      begin
         nxt_full_act = 1'b1;
      end
      if (!fifo_ths_cond || fifo_ths_rewrite)
      begin
         nxt_ths_act = 1'b0;
      end
      else if (meas_done || ths_reeval_ff)
      begin
         nxt_ths_act = 1'b1;
      end
      if (fifo_kill)
      begin
         nxt_full_act = 1'b0;
         nxt_ths_act = 1'b0;
      end
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         full_act_ff <= 1'b0;
         ths_act_ff <= 1'b0;
         full_prev_ff <= 1'b0;
         ths_prev_ff <= 1'b0;
         ths_reeval_ff <= 1'b0;
      end
      else
      begin
         full_act_ff <= nxt_full_act;
         ths_act_ff <= nxt_ths_act;
         full_prev_ff <= full_act_ff;
         ths_prev_ff <= ths_act_ff;
         // new threshold judged after the forced drop
         ths_reeval_ff <= fifo_ths_rewrite && fifo_enabled;
      end
   end

   // ****************************************
   // interrupt status
   // ****************************************
   // hardware set wins over the read clear in the same cycle
   always @*
   begin
      nxt_status = status_ff;
      if (status_rd)
      begin
         nxt_status[`SIPL_SRC_DRDY] = 1'b0;
         nxt_status[`SIPL_SRC_OOR] = 1'b0;
         nxt_status[`SIPL_STS_POR] = 1'b0;
         if (!full_act_ff)
         begin
            nxt_status[`SIPL_SRC_FULL] = 1'b0;
         end
         if (!ths_act_ff)
         begin
            nxt_status[`SIPL_SRC_THS] = 1'b0;
         end
      end
      if (fifo_ths_rewrite)
      begin
         nxt_status[`SIPL_SRC_THS] = 1'b0;
      end
      if (fifo_kill)
      begin
         nxt_status[`SIPL_SRC_FULL] = 1'b0;
         nxt_status[`SIPL_SRC_THS] = 1'b0;
      end
      if (fifo_flush)
      begin
         nxt_status[`SIPL_SRC_OOR] = 1'b0;
      end
      // status only shows enabled sources; nothing else clears it
      if (en[`SIPL_SRC_DRDY] && meas_done)
      begin
         nxt_status[`SIPL_SRC_DRDY] = 1'b1;
      end
      if (en[`SIPL_SRC_OOR] && oor_evt && !fifo_flush)
      begin
         nxt_status[`SIPL_SRC_OOR] = 1'b1;
      end
      if (en[`SIPL_SRC_FULL] && nxt_full_act)
      begin
         nxt_status[`SIPL_SRC_FULL] = 1'b1;
      end
      if (en[`SIPL_SRC_THS] && nxt_ths_act)
      begin
         nxt_status[`SIPL_SRC_THS] = 1'b1;
      end
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         // power-up flag comes up set and is reported only by status
         status_ff <= 5'h10;
      end
      else
      begin
         status_ff <= nxt_status;
      end
   end

   // ****************************************
   // source combining
   // ****************************************
   // pulsed mode looks at rising edges, latched mode at held levels
   assign pulse_src = {oor_evt, full_act_ff & ~full_prev_ff,
                       ths_act_ff & ~ths_prev_ff, meas_done};
   assign latch_src = {status_ff[`SIPL_SRC_OOR], full_act_ff, ths_act_ff,
                       status_ff[`SIPL_SRC_DRDY]};
   assign pulse_trig = |(en & pulse_src);
   assign latch_level = |(en & latch_src);
   // forced drops cut a pulse or assertion short
   assign drop_now = fifo_flush || fifo_ths_rewrite;

   // ****************************************
   // pin timing state machine
   // ****************************************
   always @*
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_asserted = asserted_ff;
      nxt_pending = pending_ff;
      if (pulse_trig)
      begin
         nxt_pending = 1'b1;
      end
      case (state_ff)
         ST_IDLE:
         begin
            nxt_asserted = 1'b0;
            if (mode_latched)
            begin
               nxt_pending = 1'b0;
               if (latch_level && pin_en)
               begin
                  nxt_state = ST_ASSERT;
                  nxt_asserted = 1'b1;
               end
            end
            else if ((pending_ff || pulse_trig) && pin_en)
            begin
               nxt_state = ST_ASSERT;
               nxt_asserted = 1'b1;
               nxt_pending = 1'b0;
               nxt_cnt = PULSE_CYC - 8'h01;
            end
         end
         ST_ASSERT:
         begin
            if (!pin_en || drop_now)
            begin
               nxt_state = ST_GAP;
               nxt_asserted = 1'b0;
               nxt_cnt = GAP_CYC - 8'h01;
            end
            else if (mode_latched)
            begin
               // a fresh data-ready during the read keeps the level up
               if (!latch_level)
               begin
                  nxt_state = ST_GAP;
                  nxt_asserted = 1'b0;
                  nxt_cnt = GAP_CYC - 8'h01;
               end
            end
            else if (cnt_ff == 8'h00)
            begin
               nxt_state = ST_GAP;
               nxt_asserted = 1'b0;
               nxt_cnt = GAP_CYC - 8'h01;
            end
            else
            begin
               nxt_cnt = cnt_ff - 8'h01;
            end
         end
         ST_GAP:
         begin
            // gap is always honoured here, the simplest legal choice
            nxt_asserted = 1'b0;
            if (cnt_ff == 8'h00)
            begin
               nxt_state = ST_IDLE;
            end
            else
            begin
               nxt_cnt = cnt_ff - 8'h01;
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
            nxt_asserted = 1'b0;
            nxt_cnt = 8'h00;
         end
      endcase
      if (!pin_en || fifo_flush)
      begin
         nxt_pending = 1'b0;
      end
   end

   always @(posedge clock)
   begin
      if (rst)
      begin
         state_ff <= ST_IDLE;
         cnt_ff <= 8'h00;
         pending_ff <= 1'b0;
         asserted_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         pending_ff <= nxt_pending;
         asserted_ff <= nxt_asserted;
      end
   end

   // ****************************************
   // register read back
   // ****************************************
   always @*
   begin
      nxt_rdata = 8'h00;
      if (reg_addr == `SIPL_ADDR_IRQ_OUTPUT_CONFIG)
      begin
         nxt_rdata = irq_output_config_ff;
      end
      else if (reg_addr == `SIPL_ADDR_IRQ_SOURCE_EN)
      begin
         nxt_rdata = irq_source_en_ff;
      end
      else if (reg_addr == `SIPL_ADDR_IRQ_STATUS)
      begin
         nxt_rdata = {3'h0, status_ff};
      end
      else if (reg_addr == `SIPL_ADDR_OOR_REF_LO)
      begin
         nxt_rdata = oor_ref_lo_ff;
      end
      else if (reg_addr == `SIPL_ADDR_OOR_REF_MID)
      begin
         nxt_rdata = oor_ref_mid_ff;
      end
      else if (reg_addr == `SIPL_ADDR_OOR_RANGE)
      begin
         nxt_rdata = oor_range_ff;
      end
      else if (reg_addr == `SIPL_ADDR_OOR_CFG)
      begin
         nxt_rdata = oor_cfg_ff;
      end
   end

   // read data holds until the next read
   always @(posedge clock)
   begin
      if (rst)
      begin
         reg_rdata_ff <= 8'h00;
      end
      else if (reg_rd)
      begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

   // ****************************************
   // pin output stage
   // ****************************************
   sipl_pin_drive u_pin
   (
      .clock(clock),
      .rst(rst),
      .asserted(asserted_ff),
      .active_high(irq_output_config_ff[`SIPL_CFG_POL]),
      .irq_drive_type(irq_output_config_ff[`SIPL_CFG_DRIVE]),
      .pin_en(pin_en),
      .irq_pin_o_ff(irq_pin_o),
      .irq_pin_oe_ff(irq_pin_oe)
   );

endmodule

/* dv/sipl_properties.sv */
// concurrent checks on the interrupt pin logic ports
`timescale 1ns/100ps
`include "sipl_defs.vh"

module sipl_properties
(
   // clock and reset
   input wire clock,
   input wire rst,
   // register port
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   // fifo
   input wire fifo_enabled,
   input wire fifo_flush,
   input wire fifo_full_cond,
   input wire fifo_ths_rewrite,
   // pin
   input wire irq_pin_o,
   input wire irq_pin_oe
);
   reg [7:0] cfg_ff;
   reg [3:0] src_ff;
   reg [2:0] age_ff;
   reg [4:0] hi_ff;
   reg [4:0] lo_ff;
   reg exc_ff;
   wire pin_lvl = irq_pin_oe ? irq_pin_o : 1'b1;
   wire act = cfg_ff[3] && (pin_lvl == cfg_ff[1]);
   wire calm = age_ff == 3'h7;
   wire lat = cfg_ff[0] && calm;

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // ************************************
   // shadow setup and pin run lengths
   // ************************************
   // checks wait for age 7, past the write-to-pin delay
   always @(posedge clock)
   begin
      if (rst)
      begin
         cfg_ff <= 8'h00;
         src_ff <= 4'h0;
         age_ff <= 3'h7;
         hi_ff <= 5'h00;
         lo_ff <= 5'h1F;
         exc_ff <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == `SIPL_ADDR_IRQ_OUTPUT_CONFIG)
            cfg_ff <= reg_wdata;
         if (reg_wr && reg_addr == `SIPL_ADDR_IRQ_SOURCE_EN)
            src_ff <= reg_wdata[3:0];
         age_ff <= (reg_wr && reg_addr < 8'h02) ? 3'h0 : calm ? 3'h7 : age_ff + 3'h1;
         hi_ff <= act ? hi_ff + 5'h01 : 5'h00;
         // a setup change exempts the gap
         lo_ff <= act ? 5'h00 : (!calm || lo_ff == 5'h1F) ? 5'h1F : lo_ff + 5'h01;
         exc_ff <= fifo_flush || fifo_ths_rewrite || !fifo_enabled || (act && exc_ff);
      end
   end

   a_pulse_length:
   assert property ($fell(act) && !cfg_ff[0] && calm && !exc_ff
      |-> hi_ff == `SIPL_PULSE_CYC) else $error("pulse length wrong");
   a_gap_kept:
   assert property ($rose(act) && calm |-> lo_ff >= `SIPL_GAP_CYC)
      else $error("deassert gap too short");
   a_drdy_holds:
   assert property (lat && src_ff == 4'h1 && act && !reg_rd && !reg_wr && !$past(reg_rd)
      && !$past(reg_rd, 2) && !$past(reg_rd, 3) |=> act) else $error("drdy released early");
   a_full_release:
   assert property (lat && src_ff == 4'h4 && !fifo_full_cond ##1 !fifo_full_cond
      ##1 !fifo_full_cond ##1 !fifo_full_cond |-> !act) else $error("full not released");
   a_flush_drop:
   assert property (fifo_flush && calm && !src_ff[0] |-> ##3 !act)
      else $error("flush did not drop pin");
   a_rewrite_drop:
   assert property (fifo_ths_rewrite && calm && src_ff == 4'h2 |-> ##3 !act)
      else $error("rewrite did not drop pin");
   a_idle_level:
   assert property (calm && src_ff == 4'h0 && cfg_ff[3] && !cfg_ff[2]
      |-> irq_pin_o == !cfg_ff[1]) else $error("idle level wrong");
   a_od_low:
   assert property (calm && cfg_ff[3] && cfg_ff[2] |-> !irq_pin_o)
      else $error("open drain drives high");
   a_pp_drives:
   assert property (calm && cfg_ff[3] && !cfg_ff[2] |-> irq_pin_oe)
      else $error("push-pull not driving");
   a_pin_off:
   assert property (calm && !cfg_ff[3] |-> !irq_pin_oe)
      else $error("disabled pin drives");
endmodule

bind sipl_top sipl_properties u_props (.*);

/* dv/sipl_host_model.sv */
// host side of the pin: pulled-up wire and a count of assertions seen
`timescale 1ns/100ps

module sipl_host_model
(
   // clock and reset
   input wire clock,
   input wire rst,
   // pin from the device and the level the host treats as active
   input wire irq_pin_o,
   input wire irq_pin_oe,
   input wire active_high,
   // what the host sees
   output wire pin_level,
   output wire pin_active,
   output reg [7:0] edge_cnt_ff
);
   reg seen_ff;

   // board pull-up: a released pin reads high
   assign pin_level = irq_pin_oe ? irq_pin_o : 1'b1;
   assign pin_active = (pin_level == active_high);

   // one count per new assertion
   always @(posedge clock)
   begin
      if (rst)
      begin
         seen_ff <= 1'b0;
         edge_cnt_ff <= 8'h00;
      end
      else
      begin
         seen_ff <= pin_active;
         if (pin_active && !seen_ff)
            edge_cnt_ff <= edge_cnt_ff + 8'h01;
      end
   end
endmodule

/* dv/tb_top.sv */
// self-checking bench for the interrupt pin logic
`timescale 1ns/100ps
`include "sipl_defs.vh"

module tb_top;
   logic clock, rst, reg_wr, reg_rd, meas_done, host_pol;
   logic fifo_enabled, fifo_flush, fifo_full_cond, fifo_ths_cond, fifo_ths_rewrite;
   logic [7:0] reg_addr, reg_wdata, d, e0;
   logic [16:0] pressure, rv, p;
   logic [31:0] seed;
   wire [7:0] reg_rdata_ff, edges;
   wire irq_pin_o, irq_pin_oe, pin_level, pin_active;
   int bad_count, tests_run;

   sipl_top dut (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
      .meas_done(meas_done), .pressure(pressure), .fifo_enabled(fifo_enabled),
      .fifo_flush(fifo_flush), .fifo_full_cond(fifo_full_cond), .fifo_ths_cond(fifo_ths_cond),
      .fifo_ths_rewrite(fifo_ths_rewrite), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));
   sipl_host_model host (.clock(clock), .rst(rst), .irq_pin_o(irq_pin_o),
      .irq_pin_oe(irq_pin_oe), .active_high(host_pol), .pin_level(pin_level),
      .pin_active(pin_active), .edge_cnt_ff(edges));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // ************************************
   // helpers
   // ************************************
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
   endfunction
   // a pressure on the window edge is inside
   function automatic oor_exp(input [16:0] x, input [16:0] r, input [7:0] w);
      oor_exp = (x > r + w) || (x < r - w);
   endfunction
   // inputs move 2 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   task automatic wr(input [7:0] a, input [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   // m: a new result in the read cycle
   task automatic rd(input [7:0] a, input bit m = 1'b0);
      reg_addr = a;
      reg_rd = 1'b1;
      meas_done = m;
      tick(1);
      reg_rd = 1'b0;
      meas_done = 1'b0;
      d = reg_rdata_ff;
      tick(1);
   endtask
   task automatic ev(input [16:0] x);
      pressure = x;
      meas_done = 1'b1;
      tick(1);
      meas_done = 1'b0;
      tick(1);
   endtask
   task automatic chk(input [7:0] g, input [7:0] x);
      tests_run++;
      if (g !== x)
      begin
         bad_count++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic chk_pin(input int n, input logic x);
      tick(n);
      chk({7'h00, pin_active}, {7'h00, x});
   endtask
   task automatic sts(input [7:0] x);
      rd(`SIPL_ADDR_IRQ_STATUS);
      chk(d, x);
   endtask
   // sources off, status read, then the style
   task automatic setup(input [7:0] c, input [3:0] s);
      wr(`SIPL_ADDR_IRQ_SOURCE_EN, 8'h00);
      rd(`SIPL_ADDR_IRQ_STATUS);
      wr(`SIPL_ADDR_IRQ_OUTPUT_CONFIG, c);
      tick(4);
      host_pol = c[1];
      wr(`SIPL_ADDR_IRQ_SOURCE_EN, {4'h0, s});
      tick(8);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (8000) @(posedge clock);
      bad_count++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      stop_test;
   end

   // ************************************
   // main sequence
   // ************************************
   initial
   begin
      {reg_wr, reg_rd, meas_done, fifo_flush, fifo_full_cond} = 5'h00;
      {fifo_ths_cond, fifo_ths_rewrite, host_pol, reg_addr, reg_wdata, pressure} = 36'h0;
      fifo_enabled = 1'b1;
      bad_count = 0;
      tests_run = 0;
      seed = 32'hE83B;
      rst = 1'b1;
      tick(3);
      rst = 1'b0;
      sts(8'h10);
      sts(8'h00);
      // pin off: any pulse here is stray
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         wr(8'(i % 2), seed[7:0] & 8'hF7);
         rd(8'(i % 2));
         chk(d, seed[7:0] & 8'h07);
      end
      rd(8'h07 + {4'h0, seed[11:8]});
      chk(d, 8'h00);
      chk(edges, 8'h00);
      $display("test registers done");
      setup(8'h0A, 4'h0);
      chk({7'h00, irq_pin_o}, 8'h00);
      wr(`SIPL_ADDR_IRQ_SOURCE_EN, 8'h01);
      tick(8);
      e0 = edges;
      ev(17'h00000);
      ev(17'h00000);
      tick(60);
      chk(edges, e0 + 8'h02);
      sts(8'h01);
      sts(8'h00);
      $display("test pulsed done");
      setup(8'h0B, 4'h1);
      ev(17'h00000);
      chk_pin(30, 1'b1);
      e0 = edges;
      rd(`SIPL_ADDR_IRQ_STATUS, 1'b1);
      chk_pin(3, 1'b1);
      chk(edges, e0);
      rd(`SIPL_ADDR_IRQ_STATUS);
      chk_pin(5, 1'b0);
      $display("test latched done");
      seed = lfsr(seed);
      rv = 17'h08000 + {2'h0, seed[14:0]};
      wr(`SIPL_ADDR_OOR_REF_LO, rv[7:0]);
      wr(`SIPL_ADDR_OOR_REF_MID, rv[15:8]);
      wr(`SIPL_ADDR_OOR_RANGE, 8'h32);
      wr(`SIPL_ADDR_OOR_CFG, {7'h00, rv[16]});
      setup(8'h0B, 4'h8);
      for (int i = 0; i < 8; i++)
      begin
         seed = lfsr(seed);
         p = (i == 0) ? rv + 17'd50 : (i == 1) ? rv + 17'd51 : rv - 17'd64 + seed[6:0];
         ev(p);
         tick(3);
         sts({4'h0, oor_exp(p, rv, 8'h32), 3'h0});
      end
      ev(rv - 17'd51);
      chk_pin(25, 1'b1);
      fifo_flush = 1'b1;
      tick(1);
      fifo_flush = 1'b0;
      chk_pin(3, 1'b0);
      sts(8'h00);
      $display("test out of range done");
      setup(8'h0B, 4'h4);
      fifo_full_cond = 1'b1;
      ev(17'h00000);
      chk_pin(25, 1'b1);
      sts(8'h04);
      chk_pin(4, 1'b1);
      fifo_full_cond = 1'b0;
      chk_pin(4, 1'b0);
      sts(8'h04);
      sts(8'h00);
      setup(8'h0B, 4'h2);
      fifo_ths_cond = 1'b1;
      ev(17'h00000);
      chk_pin(25, 1'b1);
      fifo_ths_rewrite = 1'b1;
      tick(1);
      fifo_ths_rewrite = 1'b0;
      chk_pin(3, 1'b0);
      chk_pin(25, 1'b1);
      fifo_enabled = 1'b0;
      chk_pin(4, 1'b0);
      sts(8'h00);
      fifo_ths_cond = 1'b0;
      fifo_enabled = 1'b1;
      $display("test fifo done");
      setup(8'h0C, 4'h1);
      e0 = edges;
      ev(17'h00000);
      tick(4);
      chk({7'h00, pin_level}, 8'h00);
      tick(40);
      chk(edges, e0 + 8'h01);
      setup(8'h02, 4'h1);
      ev(17'h00000);
      tick(10);
      chk({7'h00, irq_pin_oe}, 8'h00);
      sts(8'h01);
      $display("test pin styles done");
      stop_test;
   end
endmodule
